// ===== testbench/eipc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module eipc_assertions
    import eipc_pkg::*;
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Watched ports
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        irq_pin_n,
    input wire eipc_cpu_t   cpu_in,
    input wire logic        cpu_irq_req,
    input wire logic        pin_level_high
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence pin_settled;
        $stable(irq_pin_n)[*3];
    endsequence
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response changed early");
    AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted during response");
    AST_RDATA_ZERO: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hFFFFFF33) == 32'h0)
        else $error("unused or acknowledge bit read as one");
    AST_MASKED: assert property (cpu_in.i_mask |=> !cpu_irq_req)
        else $error("request raised while masked");
    AST_PIN_LEVEL: assert property (pin_settled |-> pin_level_high == irq_pin_n)
        else $error("pin level does not follow the pin");
    AST_RESET_QUIET: assert property ($rose(aresetn) |-> !cpu_irq_req && pin_level_high)
        else $error("outputs not idle after reset");
    AST_REQ_HOLDS: assert property (cpu_irq_req && !cpu_in.i_mask && !s_axi_bvalid && !cpu_in.fetch_valid
        && !$past(cpu_in.fetch_valid) |=> cpu_irq_req)
        else $error("request dropped without a clear");
endmodule
`default_nettype wire

// ===== testbench/eipc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module eipc_cpu_model
    import eipc_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Bench controls
    input  wire logic       cli,
    input  wire logic       stop,
    input  wire logic [1:0] slow,
    // Block side
    input  wire logic       cpu_irq_req,
    output var  eipc_cpu_t  cpu_in
);
    logic [2:0] step_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_in  <= '{1'b0, 16'h0000, 1'b0, 1'b1};
            step_ff <= 3'h0;
        end else begin
            cpu_in.stop_wait_exec <= stop;
            cpu_in.fetch_valid    <= step_ff == 3'h2 || step_ff == 3'h1;
            // An idle address bus keeps moving so that a stale vector is never seen.
            cpu_in.fetch_addr <= step_ff == 3'h2 ? EIPC_VEC_HI_ADDR :
                                 step_ff == 3'h1 ? EIPC_VEC_LO_ADDR : ~cpu_in.fetch_addr;
            // Entering stop or wait clears the mask bit, just as the core does.
            if (stop || cli) cpu_in.i_mask <= 1'b0;
            if (step_ff != 3'h0) step_ff <= step_ff - 3'h1;
            else if (cpu_irq_req && !cpu_in.i_mask) begin
                step_ff       <= 3'h3 + {1'b0, slow};
                cpu_in.i_mask <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== testbench/test_external_irq_port_edge_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_external_irq_port_edge_ctrl
    import eipc_pkg::*;
;
    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] dat;
        logic [7:0] drop;
        logic [7:0] exp_reg;
    } eipc_row_t;
    localparam eipc_row_t ROWS [5] = '{'{8'h00, 8'h00, 8'h01, 8'h84}, '{8'h01, 8'h00, 8'h01, 8'h80},
        '{8'h00, 8'h01, 8'h01, 8'h80}, '{8'h01, 8'h00, 8'h80, 8'h84}, '{8'hFF, 8'h00, 8'h80, 8'h80}};
    logic        aclk, aresetn, awv, wv, bry, arv, rry, pin_n, cli, stp;
    logic        awr, wrd, bv, arr, rv, req, lvl;
    logic [1:0]  br, rr, r, slow;
    logic [11:0] awa, ara;
    logic [31:0] wd, rdat, q;
    logic [7:0]  pins, dir, dat;
    eipc_cpu_t   cpu;
    int          miscompares = 0;
    int          n_tests = 0;
    int          fetches = 0;

    eipc_top #(.EDGE_AND_LEVEL(1'b0)) eipc_top_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .irq_pin_n(pin_n),
        .port_pins(pins), .port_dir(dir), .port_data(dat), .cpu_in(cpu), .cpu_irq_req(req),
        .pin_level_high(lvl));
    eipc_cpu_model eipc_cpu_model_inst (.aclk(aclk), .aresetn(aresetn), .cli(cli), .stop(stp),
        .slow(slow), .cpu_irq_req(req), .cpu_in(cpu));

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (cpu.fetch_valid && cpu.fetch_addr === EIPC_VEC_HI_ADDR) fetches++;
    end

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Ready is raised late on purpose so the slave must hold its response.
    task automatic bus(input bit w, input logic [11:0] a, input logic [7:0] d);
        bit ta, tw, td;
        int n;
        @(posedge aclk);
        awa <= a;
        ara <= a;
        wd  <= {24'h0, d};
        awv <= w;
        wv  <= w;
        arv <= !w;
        for (n = 0; n < 60; n++) begin
            #1;
            ta = w ? awr : arr;
            tw = wrd;
            td = w ? bv && bry : rv && rry;
            q  = rdat;
            r  = w ? br : rr;
            @(posedge aclk);
            if (ta) begin
                awv <= 1'b0;
                arv <= 1'b0;
            end
            if (tw) wv <= 1'b0;
            if (n == 2) begin
                bry <= w;
                rry <= !w;
            end
            if (td) break;
        end
        bry <= 1'b0;
        rry <= 1'b0;
        if (n == 60) begin
            miscompares++;
            print_verdict();
        end
    endtask
    // Whole-word writes only, never a shifted copy of the register.
    task automatic wr(input logic [7:0] d);
        bus(1'b1, EIPC_REG_BYTE_ADDR, d);
    endtask
    task automatic rdc(input logic [7:0] e, input string s);
        bus(1'b0, EIPC_REG_BYTE_ADDR, 8'h00);
        chk(s, {24'h0, e}, q);
    endtask
    task automatic unmask();
        @(posedge aclk);
        cli <= 1'b1;
        @(posedge aclk);
        cli <= 1'b0;
        repeat (14) @(posedge aclk);
    endtask

    initial begin
        {aresetn, awv, wv, bry, arv, rry, cli, stp, slow, awa, ara, wd, dir, dat} = '0;
        {pin_n, pins} = 9'h1FF;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(8'h80, "reset value");
        bus(1'b1, 12'h000, 8'hFF);
        chk("unmapped write resp", {30'h0, EIPC_RESP_SLVERR}, {30'h0, r});
        rdc(8'h80, "after unmapped write");
        $display("reset test done");
        // Open the mask first so a port flag with its enable low could really raise a request.
        unmask();
        foreach (ROWS[i]) begin
            @(posedge aclk);
            pins <= 8'hFF;
            dir  <= ROWS[i].dir;
            dat  <= ROWS[i].dat;
            repeat (8) @(posedge aclk);
            wr(8'h82);
            pins <= ~ROWS[i].drop;
            repeat (8) @(posedge aclk);
            rdc(ROWS[i].exp_reg, "port flag row");
            chk("request with port disabled", 32'h0, {31'h0, req});
        end
        $display("port table done");
        pins <= 8'hFF;
        dir  <= 8'h00;
        repeat (8) @(posedge aclk);
        wr(8'hC2);
        pins <= 8'hF7;
        repeat (8) @(posedge aclk);
        rdc(8'hC4, "port flag enabled");
        unmask();
        rdc(8'hC4, "port flag after fetch");
        slow <= 2'h3;
        unmask();
        chk("re-entry fetches", 32'd3, fetches);
        wr(8'hCC);
        rdc(8'hC4, "flag writes ignored");
        wr(8'hC2);
        rdc(8'hC0, "acknowledge clears");
        unmask();
        chk("no fetch after ack", 32'd3, fetches);
        $display("port service test done");
        pin_n <= 1'b0;
        repeat (8) @(posedge aclk);
        rdc(8'hC8, "pin flag");
        chk("pin level", 32'h0, {31'h0, lvl});
        unmask();
        rdc(8'hC0, "pin flag after fetch");
        chk("pin fetches", 32'd4, fetches);
        pin_n <= 1'b1;
        wr(8'h40);
        pin_n <= 1'b0;
        repeat (8) @(posedge aclk);
        rdc(8'h40, "pin event while disabled");
        pin_n <= 1'b1;
        stp   <= 1'b1;
        @(posedge aclk);
        stp <= 1'b0;
        repeat (4) @(posedge aclk);
        rdc(8'hC0, "stop sets pin enable");
        $display("pin test done");
        print_verdict();
    end
endmodule

bind eipc_top eipc_assertions eipc_assertions_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .irq_pin_n(irq_pin_n), .cpu_in(cpu_in), .cpu_irq_req(cpu_irq_req),
    .pin_level_high(pin_level_high));
`default_nettype wire

// ===== verilog/eipc_pkg.sv
package eipc_pkg;

    // Register placement: the printed offset is a word index.
    localparam logic [11:0] EIPC_REG_INDEX     = 12'h01F;
    localparam logic [11:0] EIPC_REG_BYTE_ADDR = 12'h07C;
    localparam int          EIPC_ADDR_W        = 12;

    // Bit positions inside the status and control register.
    localparam int EIPC_BIT_PIN_EN   = 7;
    localparam int EIPC_BIT_PORT_EN  = 6;
    localparam int EIPC_BIT_PIN_REQ  = 3;
    localparam int EIPC_BIT_PORT_REQ = 2;
    localparam int EIPC_BIT_ACK      = 1;

    // Values after reset.
    localparam logic EIPC_RST_PIN_EN   = 1'b1;
    localparam logic EIPC_RST_PORT_EN  = 1'b0;
    localparam logic EIPC_RST_PIN_REQ  = 1'b0;
    localparam logic EIPC_RST_PORT_REQ = 1'b0;

    // Shared external interrupt vector, high and low byte.
    localparam logic [15:0] EIPC_VEC_HI_ADDR = 16'h3FFA;
    localparam logic [15:0] EIPC_VEC_LO_ADDR = 16'h3FFB;

    // Number of port pins.
    localparam int EIPC_PORT_W = 8;

    localparam logic [1:0] EIPC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] EIPC_RESP_SLVERR = 2'h2;

    // Software controlled enables.
    typedef struct packed {
        logic pin_interrupt_enable;
        logic port_interrupt_enable;
    } eipc_ctrl_t;

    // Pending request flags.
    typedef struct packed {
        logic pin_request_flag;
        logic port_request_flag;
    } eipc_flags_t;

    // CPU side events presented to the block.
    typedef struct packed {
        logic        fetch_valid;
        logic [15:0] fetch_addr;
        logic        stop_wait_exec;
        logic        i_mask;
    } eipc_cpu_t;

endpackage

// ===== verilog/eipc_top.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module eipc_top
    import eipc_pkg::*;
#(
    parameter bit EDGE_AND_LEVEL = 1'b0
) (
    // Clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // AXI4-Lite write address and data
    input  wire logic [EIPC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]             s_axi_awprot,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // AXI4-Lite read
    input  wire logic [EIPC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]             s_axi_arprot,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // External pins and port state
    input  wire logic                   irq_pin_n,
    input  wire logic [EIPC_PORT_W-1:0] port_pins,
    input  wire logic [EIPC_PORT_W-1:0] port_dir,
    input  wire logic [EIPC_PORT_W-1:0] port_data,
    // CPU core
    input  wire eipc_cpu_t              cpu_in,
    output logic                        cpu_irq_req,
    output logic                        pin_level_high
);

    // Pin synchronisers: stage one feeds stage two only.
    logic [EIPC_PORT_W:0] sync1_ff;
    logic [EIPC_PORT_W:0] sync2_ff;
    logic                 pin_prev_ff;
    logic                 port_and_prev_ff;

    eipc_ctrl_t  ctrl_ff;
    eipc_ctrl_t  nxt_ctrl;
    eipc_flags_t flags_ff;
    eipc_flags_t nxt_flags;
    logic        req_ff;

    // Bus state.
    logic                   aw_held_ff;
    logic [EIPC_ADDR_W-1:0] aw_addr_ff;
    logic                   w_held_ff;
    logic [31:0]            w_data_ff;
    logic                   w_strb0_ff;
    logic                   bvalid_ff;
    logic [1:0]             bresp_ff;
    logic                   rvalid_ff;
    logic [31:0]            rdata_ff;
    logic [1:0]             rresp_ff;

    wire                    pin_sync;
    wire [EIPC_PORT_W-1:0]  port_sync;
    wire [EIPC_PORT_W-1:0]  port_qual;
    wire                    port_and;
    wire                    pin_fall;
    wire                    port_fall;
    wire                    pin_event;
    wire                    vec_fetch;
    wire                    wr_fire;
    wire                    wr_hit;
    wire                    wr_ack;
    wire                    wr_en_lane;
    wire                    rd_fire;
    wire [31:0]             reg_word;
    wire                    req_any;

    function automatic logic is_reg(input logic [EIPC_ADDR_W-1:0] a);
        is_reg = (a == EIPC_REG_BYTE_ADDR);
    endfunction

    // Asynchronous pins pass two flops before any logic sees them.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_ff <= '1;
            sync2_ff <= '1;
        end else begin
            sync1_ff <= {irq_pin_n, port_pins};
            sync2_ff <= sync1_ff;
        end
    end

    assign pin_sync  = sync2_ff[EIPC_PORT_W];
    assign port_sync = sync2_ff[EIPC_PORT_W-1:0];

    // A pin that is an output or has its data bit set is held high here,
    // so it can neither start nor hide an edge on the combined signal.
    genvar gi;
    generate
        for (gi = 0; gi < EIPC_PORT_W; gi = gi + 1) begin : g_qual
            assign port_qual[gi] = port_sync[gi] | port_dir[gi] | port_data[gi];
        end
    endgenerate

    assign port_and  = &port_qual;
    assign port_fall = port_and_prev_ff & ~port_and;
    assign pin_fall  = pin_prev_ff & ~pin_sync;
    // Level mode keeps setting the flag for as long as the pin stays low.
    assign pin_event = pin_fall | (EDGE_AND_LEVEL & ~pin_sync);

    assign vec_fetch = cpu_in.fetch_valid &
                       ((cpu_in.fetch_addr == EIPC_VEC_HI_ADDR) |
                        (cpu_in.fetch_addr == EIPC_VEC_LO_ADDR));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_prev_ff      <= 1'b1;
            port_and_prev_ff <= 1'b1;
        end else begin
            pin_prev_ff      <= pin_sync;
            port_and_prev_ff <= port_and;
        end
    end

    // Write channel: address and data are taken in either order.
    assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
    assign s_axi_wready  = ~w_held_ff & ~bvalid_ff;
    assign wr_fire       = aw_held_ff & w_held_ff & ~bvalid_ff;
    assign wr_hit        = wr_fire & is_reg(aw_addr_ff);
    assign wr_en_lane    = wr_hit & w_strb0_ff;
    assign wr_ack        = wr_en_lane & w_data_ff[EIPC_BIT_ACK];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
        end else if (s_axi_awvalid & s_axi_awready) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_ff  <= 1'b0;
            w_data_ff  <= '0;
            w_strb0_ff <= 1'b0;
        end else if (s_axi_wvalid & s_axi_wready) begin
            w_held_ff  <= 1'b1;
            w_data_ff  <= s_axi_wdata;
            w_strb0_ff <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= EIPC_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= is_reg(aw_addr_ff) ? EIPC_RESP_OKAY : EIPC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    // Enables: a stop or wait instruction sets the pin enable, outranking a software write; the port enable is left alone.
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr_en_lane) begin
            nxt_ctrl.pin_interrupt_enable  = w_data_ff[EIPC_BIT_PIN_EN];
            nxt_ctrl.port_interrupt_enable = w_data_ff[EIPC_BIT_PORT_EN];
        end
        if (cpu_in.stop_wait_exec) begin
            nxt_ctrl.pin_interrupt_enable = 1'b1;
        end
    end

    // Flags ignore written values; only clears act, and a new event wins
    // over a clear arriving in the same cycle so no request is lost.
    always_comb begin
        nxt_flags = flags_ff;
        if (wr_ack | vec_fetch) begin
            nxt_flags.pin_request_flag = 1'b0;
        end
        if (wr_ack) begin
            nxt_flags.port_request_flag = 1'b0;
        end
        if (pin_event & ctrl_ff.pin_interrupt_enable) begin
            nxt_flags.pin_request_flag = 1'b1;
        end
        if (port_fall) begin
            nxt_flags.port_request_flag = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff.pin_interrupt_enable   <= EIPC_RST_PIN_EN;
            ctrl_ff.port_interrupt_enable  <= EIPC_RST_PORT_EN;
            flags_ff.pin_request_flag      <= EIPC_RST_PIN_REQ;
            flags_ff.port_request_flag     <= EIPC_RST_PORT_REQ;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            flags_ff <= nxt_flags;
        end
    end

    // One merged request, held as long as an enabled flag is pending and the CPU mask bit is clear.
    assign req_any = (flags_ff.pin_request_flag & ctrl_ff.pin_interrupt_enable) |
                     (flags_ff.port_request_flag & ctrl_ff.port_interrupt_enable);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_ff <= 1'b0;
        end else begin
            req_ff <= req_any & ~cpu_in.i_mask;
        end
    end

    assign cpu_irq_req    = req_ff;
    // Branch instructions see the pin alone, not the port edge path.
    assign pin_level_high = pin_sync;

    // Read side: acknowledge and unused bits are always zero.
    assign reg_word = {24'h000000,
                       ctrl_ff.pin_interrupt_enable,
                       ctrl_ff.port_interrupt_enable,
                       2'h0,
                       flags_ff.pin_request_flag,
                       flags_ff.port_request_flag,
                       2'h0};

    assign s_axi_arready = ~rvalid_ff;
    assign rd_fire       = s_axi_arvalid & ~rvalid_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
            rresp_ff  <= EIPC_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= is_reg(s_axi_araddr) ? reg_word : 32'h00000000;
            rresp_ff  <= is_reg(s_axi_araddr) ? EIPC_RESP_OKAY : EIPC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;

endmodule

`default_nettype wire
